// File: shared/iod_pkg.sv
// Summary of operation
// - Opcode size types all operands unless overridden
// - Destination type drives the flag logic
// - Two-address: source read-only, destination read/write
// - Three-address: two sources, write-only dest; count
// - Result beyond 32 bits truncates, raises overflow
// - Moves 87/86/84, move address 04, class 1
// - Complement moves 8B/8A/88, class 1
// - Negate moves 8F/8E/8C, class 2
// - Two-byte 3009/3019/3035/301F leave flags unchanged
// - Interlocked swaps 1F/1E/1C, class 1
// - Field extract and insert, class 1
// - Add two and three address, class 2
// - Subtract two and three address, class 2
// - Increment and decrement, class 2
// - Multiply: class 3 two, class 4 three
// - Divide: class 3 two, class 4 three
// - Modulo: class 3 two, class 4 three
// - Left shift C0 class 5; right class 3
// - Conjunction and exclusive or, class 1
// - Inclusive or, class 1
// - Compare class 2, test 6, bit test 1
// - Clear class 2; rotate, logical shifts class 1
// - Extend sources to 32 bits, 33-bit result
// - Flags N Z V C at status bits 21..18
// - Override type codes; undefined codes raise exception
package iod_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Two-byte opcode escape byte
    localparam logic [7:0] ESC_BYTE = 8'h30;
    // Flag field positions in the status word
    localparam int FLAG_N_BIT = 21;
    localparam int FLAG_C_BIT = 18;
    localparam int DATA_W     = 32;
    // Type override codes
    localparam logic [3:0] TY_SBYTE = 4'h7;
    localparam logic [3:0] TY_SHALF = 4'h6;
    localparam logic [3:0] TY_SWORD = 4'h4;
    localparam logic [3:0] TY_UBYTE = 4'h3;
    localparam logic [3:0] TY_UHALF = 4'h2;
    localparam logic [3:0] TY_UWORD = 4'h0;
    localparam logic [3:0] TY_NONE  = 4'hF;
    ////////////////////////////////////////////////////////////////////////
    // Operand size
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } iod_size_t;
    // Flag assignment class
    typedef enum logic [2:0] {
        FC_UNCH = 3'h0,
        FC_1    = 3'h1,
        FC_2    = 3'h2,
        FC_3    = 3'h3,
        FC_4    = 3'h4,
        FC_5    = 3'h5,
        FC_6    = 3'h6
    } iod_fclass_t;
    // Operand access pattern
    typedef enum logic [1:0] {
        AM_ONE   = 2'h0,
        AM_TWO   = 2'h1,
        AM_THREE = 2'h2,
        AM_SHIFT = 2'h3
    } iod_amode_t;
    // Operation
    typedef enum logic [4:0] {
        OP_NONE, OP_MOVE, OP_MOVE_ADDR, OP_MOVE_COMPL, OP_MOVE_NEG,
        OP_MOVE_VERSION, OP_SWAP_LOCKED, OP_BLOCK_COPY, OP_FIELD_EXTRACT,
        OP_FIELD_INSERT, OP_STRING_COPY, OP_STRING_END, OP_ADD, OP_SUB,
        OP_INC, OP_DEC, OP_MUL, OP_DIV, OP_MOD, OP_ARITH_LSHIFT,
        OP_ARITH_RSHIFT, OP_AND, OP_XOR, OP_OR, OP_COMPARE, OP_TEST,
        OP_BIT_TEST, OP_CLEAR, OP_ROTATE, OP_LOGIC_LSHIFT, OP_LOGIC_RSHIFT
    } iod_op_t;
    // Per-operand access: bit5 read, bit4 write, bit3 count
    typedef struct packed {
        logic       used;
        logic       rd;
        logic       wr;
        logic       count;
        logic       sgn;
        iod_size_t  size;
    } iod_opnd_t;
    // Decoded result bundle
    typedef struct packed {
        logic        valid;
        logic        illegal;
        iod_op_t     op;
        iod_amode_t  amode;
        iod_fclass_t fclass;
        iod_size_t   size;
        iod_opnd_t   opnd0;
        iod_opnd_t   opnd1;
        iod_opnd_t   opnd2;
        iod_opnd_t   flag_type;
    } iod_dec_t;
endpackage

// File: logic/iod_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module iod_decoder (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    // Opcode from fetch
    input  wire logic                   op_valid,
    input  wire logic [15:0]            opcode,
    // Expanded-operand type codes, one per operand (4'hF none)
    input  wire logic [11:0]            type_ovr,
    // Arithmetic result check, 33-bit internal result
    input  wire logic                   res_valid,
    input  wire logic [32:0]            res_full,
    input  wire logic                   res_sgn,
    // Decoded bundle and events
    output iod_pkg::iod_dec_t           dec,
    output logic                        reserved_type,
    output logic                        int_overflow,
    output logic [31:0]                 res_out
);
    ////////////////////////////////////////////////////////////////////////
    // Combinational decode of the opcode
    iod_pkg::iod_dec_t next_dec;
    logic              next_reserved_type;
    logic              next_int_overflow;
    logic [31:0]       next_res_out;
    iod_pkg::iod_size_t  sz;     // Size from low bits
    iod_pkg::iod_fclass_t fc;    // Class
    iod_pkg::iod_op_t    op;     // Operation
    iod_pkg::iod_amode_t am;     // Access pattern
    logic                hit;    // Known opcode
    logic                sized;  // Low bits carry size

    // Size suffix decode: x7/xF/xB/x3 byte, x6/xE/xA/x2 half, else word
    always_comb begin
        case (opcode[1:0])
            2'h3:    sz = iod_pkg::SZ_BYTE;
            2'h2:    sz = iod_pkg::SZ_HALF;
            default: sz = iod_pkg::SZ_WORD;
        endcase
    end

    // Opcode table
    always_comb begin
        op    = iod_pkg::OP_NONE;
        am    = iod_pkg::AM_TWO;
        fc    = iod_pkg::FC_1;
        hit   = 1'b1;
        sized = 1'b1;
        if (opcode[15:8] == iod_pkg::ESC_BYTE) begin
            // Two-byte forms leave the flags alone
            fc    = iod_pkg::FC_UNCH;
            sized = 1'b0;
            am    = iod_pkg::AM_ONE;
            case (opcode[7:0])
                8'h09:   op = iod_pkg::OP_MOVE_VERSION;
                8'h19:   op = iod_pkg::OP_BLOCK_COPY;
                8'h35:   op = iod_pkg::OP_STRING_COPY;
                8'h1F:   op = iod_pkg::OP_STRING_END;
                default: hit = 1'b0;
            endcase
        end else if (opcode[15:8] != 8'h00) begin
            hit = 1'b0;
        end else begin
            case (opcode[7:0])
                // Moves
                8'h87, 8'h86, 8'h84: op = iod_pkg::OP_MOVE;
                8'h04: begin
                    op    = iod_pkg::OP_MOVE_ADDR;
                    sized = 1'b0;
                end
                8'h8B, 8'h8A, 8'h88: op = iod_pkg::OP_MOVE_COMPL;
                8'h8F, 8'h8E, 8'h8C: begin
                    op = iod_pkg::OP_MOVE_NEG;
                    fc = iod_pkg::FC_2;
                end
                8'h1F, 8'h1E, 8'h1C: op = iod_pkg::OP_SWAP_LOCKED;
                8'hCF, 8'hCE, 8'hCC: op = iod_pkg::OP_FIELD_EXTRACT;
                8'hCB, 8'hCA, 8'hC8: op = iod_pkg::OP_FIELD_INSERT;
                // Add and subtract
                8'h9F, 8'h9E, 8'h9C, 8'hDF, 8'hDE, 8'hDC: begin
                    op = iod_pkg::OP_ADD;
                    fc = iod_pkg::FC_2;
                    am = opcode[6] ? iod_pkg::AM_THREE : iod_pkg::AM_TWO;
                end
                8'hBF, 8'hBE, 8'hBC, 8'hFF, 8'hFE, 8'hFC: begin
                    op = iod_pkg::OP_SUB;
                    fc = iod_pkg::FC_2;
                    am = opcode[6] ? iod_pkg::AM_THREE : iod_pkg::AM_TWO;
                end
                8'h93, 8'h92, 8'h90: begin
                    op = iod_pkg::OP_INC;
                    fc = iod_pkg::FC_2;
                    am = iod_pkg::AM_ONE;
                end
                8'h97, 8'h96, 8'h94: begin
                    op = iod_pkg::OP_DEC;
                    fc = iod_pkg::FC_2;
                    am = iod_pkg::AM_ONE;
                end
                // Multiply, divide, modulo
                8'hAB, 8'hAA, 8'hA8, 8'hEB, 8'hEA, 8'hE8: begin
                    op = iod_pkg::OP_MUL;
                    fc = opcode[6] ? iod_pkg::FC_4 : iod_pkg::FC_3;
                    am = opcode[6] ? iod_pkg::AM_THREE : iod_pkg::AM_TWO;
                end
                8'hAF, 8'hAE, 8'hAC, 8'hEF, 8'hEE, 8'hEC: begin
                    op = iod_pkg::OP_DIV;
                    fc = opcode[6] ? iod_pkg::FC_4 : iod_pkg::FC_3;
                    am = opcode[6] ? iod_pkg::AM_THREE : iod_pkg::AM_TWO;
                end
                8'hA7, 8'hA6, 8'hA4, 8'hE7, 8'hE6, 8'hE4: begin
                    op = iod_pkg::OP_MOD;
                    fc = opcode[6] ? iod_pkg::FC_4 : iod_pkg::FC_3;
                    am = opcode[6] ? iod_pkg::AM_THREE : iod_pkg::AM_TWO;
                end
                // Shifts
                8'hC0: begin
                    op    = iod_pkg::OP_ARITH_LSHIFT;
                    fc    = iod_pkg::FC_5;
                    am    = iod_pkg::AM_SHIFT;
                    sized = 1'b0;
                end
                8'hC7, 8'hC6, 8'hC4: begin
                    op = iod_pkg::OP_ARITH_RSHIFT;
                    fc = iod_pkg::FC_3;
                    am = iod_pkg::AM_SHIFT;
                end
                // Logical
                8'hBB, 8'hBA, 8'hB8, 8'hFB, 8'hFA, 8'hF8: begin
                    op = iod_pkg::OP_AND;
                    am = opcode[6] ? iod_pkg::AM_THREE : iod_pkg::AM_TWO;
                end
                8'hB7, 8'hB6, 8'hB4, 8'hF7, 8'hF6, 8'hF4: begin
                    op = iod_pkg::OP_XOR;
                    am = opcode[6] ? iod_pkg::AM_THREE : iod_pkg::AM_TWO;
                end
                8'hB3, 8'hB2, 8'hB0, 8'hF3, 8'hF2, 8'hF0: begin
                    op = iod_pkg::OP_OR;
                    am = opcode[6] ? iod_pkg::AM_THREE : iod_pkg::AM_TWO;
                end
                8'h3F, 8'h3E, 8'h3C: begin
                    op = iod_pkg::OP_COMPARE;
                    fc = iod_pkg::FC_2;
                end
                8'h2B, 8'h2A, 8'h28: begin
                    op = iod_pkg::OP_TEST;
                    fc = iod_pkg::FC_6;
                    am = iod_pkg::AM_ONE;
                end
                8'h3B, 8'h3A, 8'h38: op = iod_pkg::OP_BIT_TEST;
                8'h83, 8'h82, 8'h80: begin
                    op = iod_pkg::OP_CLEAR;
                    fc = iod_pkg::FC_2;
                    am = iod_pkg::AM_ONE;
                end
                8'hD8: begin
                    op    = iod_pkg::OP_ROTATE;
                    am    = iod_pkg::AM_SHIFT;
                    sized = 1'b0;
                end
                8'hD3, 8'hD2, 8'hD0: begin
                    op = iod_pkg::OP_LOGIC_LSHIFT;
                    am = iod_pkg::AM_SHIFT;
                end
                8'hD4: begin
                    op    = iod_pkg::OP_LOGIC_RSHIFT;
                    am    = iod_pkg::AM_SHIFT;
                    sized = 1'b0;
                end
                default: hit = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand type resolution; an override carries to later operands
    function automatic iod_pkg::iod_opnd_t apply_type(
        input iod_pkg::iod_opnd_t base,
        input logic [3:0]         code
    );
        iod_pkg::iod_opnd_t r;
        r = base;
        case (code)
            iod_pkg::TY_SBYTE: begin
                r.size = iod_pkg::SZ_BYTE;
                r.sgn  = 1'b1;
            end
            iod_pkg::TY_SHALF: begin
                r.size = iod_pkg::SZ_HALF;
                r.sgn  = 1'b1;
            end
            iod_pkg::TY_SWORD: begin
                r.size = iod_pkg::SZ_WORD;
                r.sgn  = 1'b1;
            end
            iod_pkg::TY_UBYTE: begin
                r.size = iod_pkg::SZ_BYTE;
                r.sgn  = 1'b0;
            end
            iod_pkg::TY_UHALF: begin
                r.size = iod_pkg::SZ_HALF;
                r.sgn  = 1'b0;
            end
            iod_pkg::TY_UWORD: begin
                r.size = iod_pkg::SZ_WORD;
                r.sgn  = 1'b0;
            end
            default: r = base;
        endcase
        return r;
    endfunction

    // Reserved type code: 1, 5, 8..14
    function automatic logic bad_type(input logic [3:0] code);
        return (code == 4'h1) || (code == 4'h5) || (code >= 4'h8 && code <= 4'hE);
    endfunction

    iod_pkg::iod_opnd_t base_t, t0, t1, t2;
    always_comb begin
        // Opcode size with default signedness: halfword signed, others not
        base_t       = '0;
        base_t.size  = sized ? sz : iod_pkg::SZ_WORD;
        base_t.sgn   = (base_t.size == iod_pkg::SZ_HALF);
        t0 = apply_type(base_t, type_ovr[3:0]);
        t1 = apply_type(t0, type_ovr[7:4]);
        t2 = apply_type(t1, type_ovr[11:8]);
        next_dec           = '0;
        next_dec.valid     = op_valid;
        next_dec.illegal   = op_valid && !hit;
        next_dec.op        = hit ? op : iod_pkg::OP_NONE;
        next_dec.amode     = am;
        next_dec.fclass    = hit ? fc : iod_pkg::FC_UNCH;
        next_dec.size      = base_t.size;
        next_dec.opnd0     = t0;
        next_dec.opnd1     = t1;
        next_dec.opnd2     = t2;
        next_dec.opnd0.used = hit;
        case (am)
            iod_pkg::AM_ONE: begin
                // Single operand: test reads, others read-modify-write
                next_dec.opnd0.rd = 1'b1;
                next_dec.opnd0.wr = (op != iod_pkg::OP_TEST);
                next_dec.flag_type = t0;
            end
            iod_pkg::AM_TWO: begin
                next_dec.opnd0.rd   = 1'b1;
                next_dec.opnd1.used = 1'b1;
                next_dec.opnd1.rd   = 1'b1;
                next_dec.opnd1.wr   = 1'b1;
                next_dec.flag_type  = t1;
            end
            default: begin
                // Three-address or shift: count in first when shifting
                next_dec.opnd0.rd    = 1'b1;
                next_dec.opnd0.count = (am == iod_pkg::AM_SHIFT);
                next_dec.opnd1.used  = 1'b1;
                next_dec.opnd1.rd    = 1'b1;
                next_dec.opnd2.used  = 1'b1;
                next_dec.opnd2.wr    = 1'b1;
                next_dec.flag_type   = t2;
            end
        endcase
        next_reserved_type = op_valid && (bad_type(type_ovr[3:0])
                             || bad_type(type_ovr[7:4]) || bad_type(type_ovr[11:8]));
        // Truncation to 32 bits; overflow when the 33rd bit is set (unsigned) or disagrees with bit 31 (signed)
        next_res_out      = res_full[31:0];
        next_int_overflow = res_valid && (res_sgn ? (res_full[32] != res_full[31])
                                                  : res_full[32]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dec           <= '0;
            reserved_type <= 1'b0;
            int_overflow  <= 1'b0;
            res_out       <= '0;
        end else begin
            dec           <= next_dec;
            reserved_type <= next_reserved_type;
            int_overflow  <= next_int_overflow;
            res_out       <= next_res_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_illegal;
        @(posedge mclk) disable iff (!rstn)
        op_valid && opcode == 16'h0001 |=> dec.illegal;
    endproperty
    a_illegal: assert property (p_illegal) else $error("unassigned opcode not illegal");
    property p_neg_fc;
        @(posedge mclk) disable iff (!rstn)
        op_valid && opcode == 16'h008C |=> dec.fclass == iod_pkg::FC_2 && !dec.illegal;
    endproperty
    a_neg_fc: assert property (p_neg_fc) else $error("negate class wrong");
    property p_esc;
        @(posedge mclk) disable iff (!rstn)
        op_valid && opcode == 16'h3019 |=> dec.fclass == iod_pkg::FC_UNCH && dec.valid;
    endproperty
    a_esc: assert property (p_esc) else $error("two-byte class wrong");
    property p_mul3;
        @(posedge mclk) disable iff (!rstn)
        op_valid && opcode == 16'h00E8 |=> dec.fclass == iod_pkg::FC_4 && dec.opnd2.wr;
    endproperty
    a_mul3: assert property (p_mul3) else $error("multiply three class wrong");
    property p_two_rw;
        @(posedge mclk) disable iff (!rstn)
        next_dec.amode == iod_pkg::AM_TWO && op_valid |=> dec.opnd1.rd && dec.opnd1.wr
                                                        && !dec.opnd0.wr;
    endproperty
    a_two_rw: assert property (p_two_rw) else $error("two-address access wrong");
    property p_shift_cnt;
        @(posedge mclk) disable iff (!rstn)
        op_valid && opcode == 16'h00D4 |=> dec.opnd0.count && !dec.opnd2.rd;
    endproperty
    a_shift_cnt: assert property (p_shift_cnt) else $error("shift count wrong");
    property p_ovf;
        @(posedge mclk) disable iff (!rstn)
        res_valid && !res_sgn && res_full[32] |=> int_overflow;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow missed");
    property p_rsv;
        @(posedge mclk) disable iff (!rstn)
        op_valid && type_ovr[3:0] == 4'h5 |=> reserved_type;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved type missed");
    property p_ovr;
        @(posedge mclk) disable iff (!rstn)
        op_valid && opcode == 16'h0087 && type_ovr == 12'hFF2 |=>
            dec.opnd1.size == iod_pkg::SZ_HALF && dec.flag_type.size == iod_pkg::SZ_HALF;
    endproperty
    a_ovr: assert property (p_ovr) else $error("override not carried");
    // An illegal opcode must carry no operation and no flag update
    property p_ill_unch;
        @(posedge mclk) disable iff (!rstn)
        dec.illegal |-> dec.fclass == iod_pkg::FC_UNCH && dec.op == iod_pkg::OP_NONE;
    endproperty
    a_ill_unch: assert property (p_ill_unch) else $error("illegal opcode not inert");
    c_add3: cover property (@(posedge mclk) disable iff (!rstn) dec.op == iod_pkg::OP_ADD
                            && dec.amode == iod_pkg::AM_THREE);
    c_ill: cover property (@(posedge mclk) disable iff (!rstn) dec.illegal);
    c_ovf: cover property (@(posedge mclk) disable iff (!rstn) int_overflow);
endmodule
`default_nettype wire

// File: verif/iod_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module iod_fetch_model (
    // Opcode and type overrides toward the decoder
    output var logic        op_valid,
    output var logic [15:0] opcode,
    output var logic [11:0] type_ovr
);
    ////////////////////////////////////////////////////////////////////////
    // Idle state before the first request
    initial begin
        op_valid = 1'b0;
        opcode   = 16'h0000;
        type_ovr = 12'hFFF;
    end

    ////////////////////////////////////////////////////////////////////////
    // Present one opcode; the caller sits just after a falling edge
    task automatic put(input logic [15:0] opc, input logic [11:0] ovr);
        op_valid = 1'b1;
        opcode   = opc;
        type_ovr = ovr;
    endtask

    // Withdraw; lines show inverted values so a stale opcode never matches
    task automatic idle();
        op_valid = 1'b0;
        opcode   = ~opcode;
        type_ovr = ~type_ovr;
    endtask
endmodule
`default_nettype wire

// File: verif/tb_integer_opcode_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_integer_opcode_decoder;
    logic              mclk;          // Core clock
    logic              rstn;          // Active-low reset
    logic              op_valid;      // Opcode strobe from fetch model
    logic [15:0]       opcode;        // Opcode from fetch model
    logic [11:0]       type_ovr;      // Type overrides from fetch model
    logic              res_valid;     // Result check strobe
    logic [32:0]       res_full;      // Internal 33-bit result
    logic              res_sgn;       // Signed destination
    iod_pkg::iod_dec_t dec;           // Decoded bundle
    logic              reserved_type; // Bad type code event
    logic              int_overflow;  // Overflow event
    logic [31:0]       res_out;       // Truncated result
    int                bad_count;     // Mismatches
    int                n_tests;       // Comparisons
    int                cyc;           // Cycles run

    iod_fetch_model iod_fetch_model_i (.op_valid(op_valid), .opcode(opcode),
        .type_ovr(type_ovr));
    iod_decoder iod_decoder_i (.mclk(mclk), .rstn(rstn), .op_valid(op_valid),
        .opcode(opcode), .type_ovr(type_ovr), .res_valid(res_valid),
        .res_full(res_full), .res_sgn(res_sgn), .dec(dec),
        .reserved_type(reserved_type), .int_overflow(int_overflow), .res_out(res_out));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic results();
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Compare one value
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Issue one opcode back to back and check its decode one cycle later
    task automatic d(input logic [15:0] opc, input iod_pkg::iod_op_t op,
                     input int fc, input int sz, input int am);
        iod_fetch_model_i.put(opc, 12'hFFF);
        @(negedge mclk);
        cmp(dec.valid, 1'b1);
        cmp(dec.illegal, 1'b0);
        cmp(dec.op, op);
        cmp(dec.fclass, fc[2:0]);
        cmp(dec.size, sz[1:0]);
        if (am >= 0) cmp(dec.amode, am[1:0]);
        if (am == 1 || am == 2) cmp(dec.opnd0.size, sz[1:0]);
    endtask
    // Drive one result check and compare the events
    task automatic ov(input logic v, input logic s, input logic [32:0] f, input logic e);
        res_valid = v;
        res_sgn   = s;
        res_full  = f;
        @(negedge mclk);
        cmp(int_overflow, e);
        cmp(res_out, f[31:0]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        res_valid = 1'b1;
        res_full  = 33'h1_0000_0000;
        iod_fetch_model_i.put(16'h009C, 12'hFFF);
        repeat (3) @(negedge mclk);
        cmp(dec.valid, 1'b0);
        cmp(int_overflow, 1'b0);
        cmp(res_out, 32'h0000_0000);
        res_valid = 1'b0;
    endtask
    task automatic t_table();
        d(16'h0087, iod_pkg::OP_MOVE, 1, 0, 1);
        d(16'h0086, iod_pkg::OP_MOVE, 1, 1, 1);
        d(16'h0084, iod_pkg::OP_MOVE, 1, 2, 1);
        d(16'h0004, iod_pkg::OP_MOVE_ADDR, 1, 2, 1);
        d(16'h008B, iod_pkg::OP_MOVE_COMPL, 1, 0, 1);
        d(16'h008C, iod_pkg::OP_MOVE_NEG, 2, 2, 1);
        d(16'h3009, iod_pkg::OP_MOVE_VERSION, 0, 2, 0);
        d(16'h3019, iod_pkg::OP_BLOCK_COPY, 0, 2, 0);
        d(16'h3035, iod_pkg::OP_STRING_COPY, 0, 2, 0);
        d(16'h301F, iod_pkg::OP_STRING_END, 0, 2, 0);
        d(16'h001E, iod_pkg::OP_SWAP_LOCKED, 1, 1, -1);
        d(16'h00CF, iod_pkg::OP_FIELD_EXTRACT, 1, 0, -1);
        d(16'h00C8, iod_pkg::OP_FIELD_INSERT, 1, 2, -1);
        d(16'h009F, iod_pkg::OP_ADD, 2, 0, 1);
        d(16'h00DE, iod_pkg::OP_ADD, 2, 1, 2);
        d(16'h00FF, iod_pkg::OP_SUB, 2, 0, 2);
        d(16'h0093, iod_pkg::OP_INC, 2, 0, 0);
        d(16'h0094, iod_pkg::OP_DEC, 2, 2, 0);
        d(16'h00AA, iod_pkg::OP_MUL, 3, 1, 1);
        d(16'h00E8, iod_pkg::OP_MUL, 4, 2, 2);
        d(16'h00AF, iod_pkg::OP_DIV, 3, 0, 1);
        d(16'h00EC, iod_pkg::OP_DIV, 4, 2, 2);
        d(16'h00A4, iod_pkg::OP_MOD, 3, 2, 1);
        d(16'h00E6, iod_pkg::OP_MOD, 4, 1, 2);
        d(16'h00C0, iod_pkg::OP_ARITH_LSHIFT, 5, 2, -1);
        d(16'h00C7, iod_pkg::OP_ARITH_RSHIFT, 3, 0, -1);
        d(16'h00F8, iod_pkg::OP_AND, 1, 2, 2);
        d(16'h00B6, iod_pkg::OP_XOR, 1, 1, 1);
        d(16'h00F2, iod_pkg::OP_OR, 1, 1, 2);
        d(16'h003F, iod_pkg::OP_COMPARE, 2, 0, -1);
        d(16'h002A, iod_pkg::OP_TEST, 6, 1, 0);
        d(16'h0038, iod_pkg::OP_BIT_TEST, 1, 2, -1);
        d(16'h0082, iod_pkg::OP_CLEAR, 2, 1, 0);
        d(16'h00D8, iod_pkg::OP_ROTATE, 1, 2, -1);
        d(16'h00D3, iod_pkg::OP_LOGIC_LSHIFT, 1, 0, -1);
        d(16'h00D4, iod_pkg::OP_LOGIC_RSHIFT, 1, 2, -1);
    endtask
    task automatic t_access();
        iod_fetch_model_i.put(16'h009C, 12'hF27);
        @(negedge mclk);
        cmp({dec.opnd0.rd, dec.opnd0.wr, dec.opnd1.rd, dec.opnd1.wr}, 4'hB);
        cmp({dec.flag_type.size, dec.flag_type.sgn}, 3'h2);
        iod_fetch_model_i.put(16'h00DC, 12'h427);
        @(negedge mclk);
        cmp({dec.opnd0.rd, dec.opnd0.wr, dec.opnd1.rd, dec.opnd1.wr}, 4'hA);
        cmp({dec.opnd2.rd, dec.opnd2.wr}, 2'h1);
        cmp({dec.flag_type.size, dec.flag_type.sgn}, 3'h5);
        iod_fetch_model_i.put(16'h00C4, 12'hFFF);
        @(negedge mclk);
        cmp({dec.opnd0.count, dec.opnd0.wr, dec.opnd2.wr}, 3'h5);
    endtask
    task automatic t_types();
        logic [1:0] sz;
        logic       bad;
        for (int c = 0; c < 15; c++) begin
            iod_fetch_model_i.put(16'h0084, {8'hFF, c[3:0]});
            @(negedge mclk);
            bad = (c == 1 || c == 5 || c > 7);
            sz  = (c == 7 || c == 3) ? 2'h0 : (c == 6 || c == 2) ? 2'h1 : 2'h2;
            cmp(reserved_type, bad);
            if (!bad) cmp({dec.opnd1.size, dec.opnd1.sgn}, {sz, c[2]});
        end
        iod_fetch_model_i.put(16'h0087, 12'hF27);
        @(negedge mclk);
        cmp({dec.opnd0.size, dec.opnd0.sgn}, 3'h1);
        cmp({dec.flag_type.size, dec.flag_type.sgn}, 3'h2);
        iod_fetch_model_i.put(16'h0087, 12'hFF2);
        @(negedge mclk);
        cmp({dec.opnd1.size, dec.opnd1.sgn}, 3'h2);
    endtask
    task automatic t_illegal();
        iod_fetch_model_i.put(16'h1200, 12'hFFF);
        @(negedge mclk);
        cmp(dec.illegal, 1'b1);
        cmp(dec.op, iod_pkg::OP_NONE);
        cmp(dec.fclass, iod_pkg::FC_UNCH);
        iod_fetch_model_i.put(16'h0001, 12'hFFF);
        @(negedge mclk);
        cmp(dec.illegal, 1'b1);
    endtask
    task automatic t_ovf();
        ov(1'b1, 1'b0, 33'h1_0000_0005, 1'b1);
        ov(1'b1, 1'b1, 33'h0_8000_0000, 1'b1);
        ov(1'b1, 1'b1, 33'h1_FFFF_FFFF, 1'b0);
        ov(1'b1, 1'b0, 33'h0_FFFF_FFFF, 1'b0);
        ov(1'b0, 1'b0, 33'h1_0000_0000, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rstn      = 1'b0;
        res_valid = 1'b0;
        res_full  = 33'h0_0000_0000;
        res_sgn   = 1'b0;
        bad_count = 0;
        n_tests   = 0;
        cyc       = 0;
        repeat (6) @(negedge mclk);
        t_reset();
        repeat (1) @(negedge mclk);
        rstn = 1'b1;
        t_table();
        t_access();
        t_types();
        t_illegal();
        iod_fetch_model_i.idle();
        t_ovf();
        results();
    end
endmodule
`default_nettype wire
